/* File: terminator_pkg.sv */
package terminator_pkg;
  // transaction bus timeout
  localparam int TIMEOUT_MS = 256;
  localparam int CLK_KHZ = 250000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
  localparam int TMR_W = 26;
  localparam int CLEAR_CYCLES = 8;
  localparam int CLR_W = 4;
  // processor bus address layout
  localparam int ADDR_W = 32;
  localparam int UPPER_HI = 31;
  localparam int UPPER_LO = 17;
  localparam int UPPER_W = UPPER_HI - UPPER_LO + 1;
  localparam int SHELF_HI = 24;
  localparam int SHELF_LO = 22;
  localparam int SHELF_W = SHELF_HI - SHELF_LO + 1;
  localparam int NUM_SHELVES = 8;
  localparam int REGION_HI = 16;
  localparam int REGION_LO = 12;
  localparam logic [4:0] PROM_REGION = 5'h1f;
  localparam int PSEL_HI = 11;
  localparam int PSEL_LO = 10;
  localparam int PADDR_HI = 9;
  localparam int PADDR_LO = 2;
  localparam int PROM_AW = 8;
  localparam int NUM_PROMS = 4;
  localparam int PROM_WAIT_CYCLES = 4;
  localparam int WAIT_W = 3;
  // output reset values
  localparam logic LOCK_N_RST = 1'b1;
  localparam logic DTACK_N_RST = 1'b1;
endpackage

/* File: sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pin levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: timeout_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module timeout_timer
  import terminator_pkg::*;
#(
  parameter int LIMIT = TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic stop,
  // status
  output logic busy,
  output logic expired,
  output logic [TMR_W-1:0] count
);
  localparam logic [TMR_W-1:0] LAST = TMR_W'(LIMIT - 1);

  // a new cycle restarts the count even if the previous one is still open
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      count <= '0;
    end else if (start) begin
      busy <= 1'b1;
      count <= '0;
    end else if (stop) begin
      busy <= 1'b0;
    end else if (busy) begin
      if (count == LAST) begin
        busy <= 1'b0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= busy && !start && !stop && (count == LAST);
    end
  end
endmodule
`default_nettype wire

/* File: bus_terminator_timeout_ctrl.sv */
//Contract
// - an address cycle with no acknowledge counts as a timeout
// - a data cycle with no acknowledge counts as a timeout
// - the timeout interval is 256 ms
// - a timeout drives the transaction bus clear signals
// - switch_active_n low means this message switch is active
// - while active, converter_switch_lock_n is asserted to lock faceplate switches
// - processor shelf card drives the extender enables of every shelf
// - drive processor bus address bits 31 to 17 onto secondary shelves
// - shelf_data_strobe only for accesses that target a secondary shelf
// - processor bus master reads the four identification PROMs through buffers
`timescale 1ns/1ps
`default_nettype none
module bus_terminator_timeout_ctrl
  import terminator_pkg::*;
#(
  parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // transaction bus
  input wire logic address_cycle_valid,
  input wire logic data_cycle_valid,
  input wire logic cycle_ack,
  output logic bus_clear,
  output logic clear_after_data,
  // power converters
  input wire logic switch_active_n,
  output logic converter_switch_lock_n,
  // extender boards
  input wire logic processor_shelf,
  input wire logic extender_enable_req,
  output logic [NUM_SHELVES-1:0] extender_enable,
  // processor bus
  input wire logic pbus_ds_n,
  input wire logic pbus_write,
  input wire logic [ADDR_W-1:0] pbus_addr,
  input wire logic [SHELF_W-1:0] shelf_id,
  output logic [UPPER_W-1:0] upper_addr,
  output logic upper_addr_oe,
  output logic shelf_data_strobe,
  output logic [7:0] pbus_rdata,
  output logic pbus_rdata_oe,
  output logic pbus_dtack_n,
  // identification proms
  output logic [NUM_PROMS-1:0] prom_sel,
  output logic [PROM_AW-1:0] prom_addr,
  input wire logic [NUM_PROMS*8-1:0] prom_data
);
  localparam int SYNC_W = 8 + SHELF_W + ADDR_W + NUM_PROMS * 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = {3'h0, 1'b1, 2'h0, 1'b1, {(SYNC_W - 7){1'b0}}};
  localparam logic [CLR_W-1:0] CLEAR_LAST = CLR_W'(CLEAR_CYCLES - 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(PROM_WAIT_CYCLES - 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(TIMEOUT_LIMIT - 1);

  typedef enum logic [1:0] {P_IDLE, P_WAIT, P_DONE} prom_state_t;

  logic addr_s, data_s, ack_s, active_n_s, proc_s, ext_req_s, ds_n_s, write_s;
  logic [SHELF_W-1:0] shelf_s;
  logic [ADDR_W-1:0] addr_bus_s;
  logic [NUM_PROMS*8-1:0] prom_s;
  logic addr_prev_q, data_prev_q;
  logic addr_start, data_start, tmr_start;
  logic tmr_busy, tmr_expired;
  logic [TMR_W-1:0] tmr_count;
  logic [CLR_W-1:0] clear_cnt_q;
  logic ds_act, secondary, prom_req;
  prom_state_t prom_state_q;
  logic [WAIT_W-1:0] wait_q;
  logic [1:0] prom_idx_q;

  function automatic logic targets_secondary(input logic [ADDR_W-1:0] a,
                                             input logic [SHELF_W-1:0] own);
    targets_secondary = a[SHELF_HI:SHELF_LO] != own;
  endfunction

  function automatic logic in_prom_region(input logic [ADDR_W-1:0] a);
    in_prom_region = a[REGION_HI:REGION_LO] == PROM_REGION;
  endfunction

  // every backplane pin is asynchronous to sys_clk
  sync2 #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({address_cycle_valid, data_cycle_valid, cycle_ack, switch_active_n, processor_shelf,
        extender_enable_req, pbus_ds_n, pbus_write, shelf_id, pbus_addr, prom_data}),
    .q({addr_s, data_s, ack_s, active_n_s, proc_s, ext_req_s, ds_n_s, write_s, shelf_s,
        addr_bus_s, prom_s})
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_prev_q <= 1'b0;
      data_prev_q <= 1'b0;
    end else begin
      addr_prev_q <= addr_s;
      data_prev_q <= data_s;
    end
  end

  assign addr_start = addr_s && !addr_prev_q;
  assign data_start = data_s && !data_prev_q;
  assign tmr_start = addr_start || data_start;

  timeout_timer #(.LIMIT(TIMEOUT_LIMIT)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(tmr_start),
    .stop(ack_s),
    .busy(tmr_busy),
    .expired(tmr_expired),
    .count(tmr_count)
  );

  // clear is held a fixed number of cycles so every port card sees it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_clear <= 1'b0;
      clear_cnt_q <= '0;
    end else if (tmr_expired) begin
      bus_clear <= 1'b1;
      clear_cnt_q <= '0;
    end else if (bus_clear) begin
      if (clear_cnt_q == CLEAR_LAST) begin
        bus_clear <= 1'b0;
      end else begin
        clear_cnt_q <= clear_cnt_q + 1'b1;
      end
    end
  end

  // remembers which kind of cycle went unanswered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_after_data <= 1'b0;
    end else if (tmr_start) begin
      clear_after_data <= data_start && !addr_start;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_switch_lock_n <= LOCK_N_RST;
    end else begin
      converter_switch_lock_n <= active_n_s;
    end
  end

  // only the processor shelf card may enable extenders; others keep them off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      extender_enable <= '0;
    end else begin
      extender_enable <= {NUM_SHELVES{proc_s && ext_req_s}};
    end
  end

  assign ds_act = !ds_n_s;
  assign secondary = targets_secondary(addr_bus_s, shelf_s);
  assign prom_req = ds_act && !write_s && !secondary && in_prom_region(addr_bus_s);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_addr <= '0;
      upper_addr_oe <= 1'b0;
      shelf_data_strobe <= 1'b0;
    end else begin
      upper_addr <= addr_bus_s[UPPER_HI:UPPER_LO];
      upper_addr_oe <= ds_act && secondary;
      shelf_data_strobe <= ds_act && secondary;
    end
  end

  // prom data passes the synchroniser, hence the fixed wait before sampling
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prom_state_q <= P_IDLE;
      wait_q <= '0;
      prom_idx_q <= '0;
      prom_sel <= '0;
      prom_addr <= '0;
      pbus_rdata <= '0;
      pbus_rdata_oe <= 1'b0;
      pbus_dtack_n <= DTACK_N_RST;
    end else begin
      unique case (prom_state_q)
        P_IDLE: begin
          if (prom_req) begin
            prom_idx_q <= addr_bus_s[PSEL_HI:PSEL_LO];
            prom_sel <= NUM_PROMS'(1) << addr_bus_s[PSEL_HI:PSEL_LO];
            prom_addr <= addr_bus_s[PADDR_HI:PADDR_LO];
            wait_q <= '0;
            prom_state_q <= P_WAIT;
          end
        end
        P_WAIT: begin
          if (wait_q == WAIT_LAST) begin
            pbus_rdata <= prom_s[prom_idx_q*8 +: 8];
            pbus_rdata_oe <= 1'b1;
            pbus_dtack_n <= 1'b0;
            prom_state_q <= P_DONE;
          end else begin
            wait_q <= wait_q + 1'b1;
          end
        end
        P_DONE: begin
          if (!ds_act) begin
            prom_sel <= '0;
            pbus_rdata_oe <= 1'b0;
            pbus_dtack_n <= 1'b1;
            prom_state_q <= P_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_clear_hold;
    bus_clear [*8] ##1 !bus_clear;
  endsequence

  sequence s_prom_answer;
    ##[1:8] (!pbus_dtack_n && pbus_rdata_oe);
  endsequence

  property p_addr_start;
    addr_start |=> tmr_busy && tmr_count == '0 && !clear_after_data;
  endproperty
  a_addr_start: assert property (p_addr_start) else $error("address cycle not timed");

  property p_data_start;
    data_start && !addr_start |=> tmr_busy && clear_after_data;
  endproperty
  a_data_start: assert property (p_data_start) else $error("data cycle not timed");

  property p_fire_count;
    tmr_expired |-> $past(tmr_count) == TMR_LAST && !$past(tmr_busy, 2) == 1'b0;
  endproperty
  a_fire_count: assert property (p_fire_count) else $error("timeout at wrong count");

  property p_clear;
    tmr_expired |=> s_clear_hold;
  endproperty
  a_clear: assert property (p_clear) else $error("bus clear not held");

  property p_lock;
    !active_n_s |=> !converter_switch_lock_n;
  endproperty
  a_lock: assert property (p_lock) else $error("active switch not locked");

  property p_unlock;
    active_n_s |=> converter_switch_lock_n;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock not released");

  property p_ext;
    extender_enable != '0 |-> $past(proc_s) && &extender_enable;
  endproperty
  a_ext: assert property (p_ext) else $error("extender enable wrong");

  property p_upper;
    ds_act && secondary |=> upper_addr_oe && upper_addr == $past(addr_bus_s[UPPER_HI:UPPER_LO]);
  endproperty
  a_upper: assert property (p_upper) else $error("upper address not driven");

  property p_strobe;
    shelf_data_strobe |-> $past(ds_act) && $past(secondary);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without secondary access");

  property p_prom;
    prom_state_q == P_IDLE && prom_req |-> s_prom_answer;
  endproperty
  a_prom: assert property (p_prom) else $error("prom read not answered");

  property p_ack_stop;
    tmr_busy && ack_s && !tmr_start |=> !tmr_busy ##1 !tmr_expired;
  endproperty
  a_ack_stop: assert property (p_ack_stop) else $error("acknowledge did not stop timer");

  property p_restart;
    tmr_busy && tmr_start |=> tmr_busy && tmr_count == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear count");

  property p_local_quiet;
    ds_act && !secondary |=> !shelf_data_strobe && !upper_addr_oe;
  endproperty
  a_local_quiet: assert property (p_local_quiet) else $error("local access strobed");

  property p_ext_off;
    !ext_req_s || !proc_s |=> extender_enable == '0;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("extenders on without request");

  property p_write_refused;
    prom_state_q == P_IDLE && ds_act && write_s |=> prom_state_q == P_IDLE && pbus_dtack_n;
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write answered");
endmodule
`default_nettype wire

/* File: id_prom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module id_prom_model
  import terminator_pkg::*;
(
  // select and byte address from the card
  input wire logic [NUM_PROMS-1:0] prom_sel,
  input wire logic [PROM_AW-1:0] prom_addr,
  // one byte per prom
  output logic [NUM_PROMS*8-1:0] prom_data
);
  // arbitrary content; a deselected prom shows the inverse, not its byte
  always_comb begin
    for (int k = 0; k < NUM_PROMS; k++) begin
      prom_data[8*k +: 8] = (8'(k * 'h41) ^ prom_addr) ^ {8{~prom_sel[k]}};
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import terminator_pkg::*;
  localparam int LIM = 20;
  logic sys_clk, rst_n, address_cycle_valid, data_cycle_valid, cycle_ack, bus_clear;
  logic clear_after_data, switch_active_n, converter_switch_lock_n, processor_shelf;
  logic extender_enable_req, pbus_ds_n, pbus_write, upper_addr_oe, shelf_data_strobe;
  logic pbus_rdata_oe, pbus_dtack_n;
  logic [NUM_SHELVES-1:0] extender_enable;
  logic [ADDR_W-1:0] pbus_addr;
  logic [SHELF_W-1:0] shelf_id;
  logic [UPPER_W-1:0] upper_addr;
  logic [7:0] pbus_rdata;
  logic [NUM_PROMS-1:0] prom_sel;
  logic [PROM_AW-1:0] prom_addr;
  logic [NUM_PROMS*8-1:0] prom_data;
  int fail_count, checks_done, lat, hits;

  bus_terminator_timeout_ctrl #(.TIMEOUT_LIMIT(LIM)) bus_terminator_timeout_ctrl_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .address_cycle_valid(address_cycle_valid),
    .data_cycle_valid(data_cycle_valid), .cycle_ack(cycle_ack), .bus_clear(bus_clear),
    .clear_after_data(clear_after_data), .switch_active_n(switch_active_n),
    .converter_switch_lock_n(converter_switch_lock_n), .processor_shelf(processor_shelf),
    .extender_enable_req(extender_enable_req), .extender_enable(extender_enable),
    .pbus_ds_n(pbus_ds_n), .pbus_write(pbus_write), .pbus_addr(pbus_addr),
    .shelf_id(shelf_id), .upper_addr(upper_addr), .upper_addr_oe(upper_addr_oe),
    .shelf_data_strobe(shelf_data_strobe), .pbus_rdata(pbus_rdata),
    .pbus_rdata_oe(pbus_rdata_oe), .pbus_dtack_n(pbus_dtack_n), .prom_sel(prom_sel),
    .prom_addr(prom_addr), .prom_data(prom_data));
  id_prom_model id_prom_model_i (.prom_sel(prom_sel), .prom_addr(prom_addr),
    .prom_data(prom_data));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // edges until the watched output reaches lvl; bounded so a hang ends the run
  task automatic wait_for(input int which, input logic lvl, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
      case (which)
        0: s = converter_switch_lock_n;
        1: s = bus_clear;
        2: s = shelf_data_strobe;
        default: s = pbus_dtack_n;
      endcase
      if (n > 200) begin
        check(0, 1, "wait bound used up");
        tally_and_finish();
      end
    end while (s !== lvl);
  endtask

  task automatic t_lock();
    switch_active_n = 1'b0;
    wait_for(0, 1'b0, lat);
    check(lat, 3, "lock latency");
    cyc(10);
    check(converter_switch_lock_n, 0, "lock held");
    switch_active_n = 1'b1;
    wait_for(0, 1'b1, lat);
    check(lat, 3, "unlock latency");
    cyc(1);
  endtask

  task automatic t_ext();
    processor_shelf = 1'b1;
    extender_enable_req = 1'b1;
    cyc(4);
    check(extender_enable, 8'hff, "extenders on");
    processor_shelf = 1'b0;
    cyc(4);
    check(extender_enable, 8'h00, "not processor shelf");
    processor_shelf = 1'b1;
    extender_enable_req = 1'b0;
    cyc(4);
    check(extender_enable, 8'h00, "extenders off");
  endtask

  // address cycle restarted by a data cycle late in the count when restart is set
  task automatic t_timeout(input logic restart);
    address_cycle_valid = 1'b1;
    if (restart) begin
      cyc(LIM - 5);
      data_cycle_valid = 1'b1;
    end
    wait_for(1, 1'b1, lat);
    check(lat, LIM + 4, "timeout latency");
    check(clear_after_data, restart, "clear kind");
    wait_for(1, 1'b0, lat);
    check(lat, CLEAR_CYCLES, "clear width");
    cyc(1);
    address_cycle_valid = 1'b0;
    data_cycle_valid = 1'b0;
    cyc(2);
  endtask

  task automatic t_ack();
    address_cycle_valid = 1'b1;
    cyc(LIM / 2);
    cycle_ack = 1'b1;
    hits = 0;
    repeat (LIM + 20) begin
      cyc(1);
      if (bus_clear !== 1'b0) hits++;
    end
    check(hits, 0, "acked cycle cleared bus");
    cycle_ack = 1'b0;
    address_cycle_valid = 1'b0;
    cyc(2);
  endtask

  // processor bus cycle as the switch processor runs it
  task automatic t_access(input logic [31:0] a, input logic wr, input int which);
    pbus_addr = a;
    pbus_write = wr;
    pbus_ds_n = 1'b0;
    hits = 0;
    repeat (12) begin
      cyc(1);
      if (which == 2 && shelf_data_strobe !== 1'b0) hits++;
      if (which == 3 && pbus_dtack_n !== 1'b1) hits++;
    end
    check(hits, 0, "refused access answered");
    pbus_ds_n = 1'b1;
    cyc(4);
  endtask

  task automatic t_secondary(input logic [31:0] a);
    pbus_addr = a;
    pbus_write = 1'b0;
    pbus_ds_n = 1'b0;
    wait_for(2, 1'b1, lat);
    check(lat, 3, "strobe latency");
    check(upper_addr, a[31:17], "upper address");
    check(upper_addr_oe, 1, "upper address driven");
    cyc(1);
    pbus_ds_n = 1'b1;
    wait_for(2, 1'b0, lat);
    check(lat, 3, "strobe release");
    check(upper_addr_oe, 0, "upper address released");
    cyc(1);
  endtask

  task automatic t_prom(input int k, input logic [7:0] a);
    pbus_addr = {7'h00, 3'h2, 5'h00, 5'h1f, 2'(k), a, 2'h0};
    pbus_write = 1'b0;
    pbus_ds_n = 1'b0;
    wait_for(3, 1'b0, lat);
    check(lat, 7, "prom acknowledge latency");
    check(pbus_rdata, 8'(k * 'h41) ^ a, "prom byte");
    check({pbus_rdata_oe, prom_sel, prom_addr}, {1'b1, 4'h1 << k, a}, "prom select");
    cyc(1);
    pbus_ds_n = 1'b1;
    wait_for(3, 1'b1, lat);
    check({lat[3:0], pbus_rdata_oe}, {4'h3, 1'b0}, "prom release");
    cyc(1);
  endtask

  initial begin
    {rst_n, address_cycle_valid, data_cycle_valid, cycle_ack, processor_shelf} = '0;
    {extender_enable_req, pbus_write} = '0;
    {switch_active_n, pbus_ds_n} = 2'h3;
    pbus_addr = 32'h0000_0000;
    shelf_id = 3'h2;
    fail_count = 0;
    checks_done = 0;
    cyc(12);
    rst_n = 1'b1;
    cyc(3);
    check({converter_switch_lock_n, pbus_dtack_n, bus_clear, shelf_data_strobe}, 4'hc,
          "idle after reset");
    t_lock();
    t_ext();
    t_timeout(1'b0);
    t_timeout(1'b1);
    t_ack();
    t_secondary(32'hfffe_0000);
    t_secondary(32'h8002_0000);
    t_access(32'h0080_0000, 1'b0, 2);
    for (int k = 0; k < NUM_PROMS; k++) t_prom(k, 8'(k * 'h55));
    t_access(32'h0081_f000, 1'b1, 3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
